/* File: bcs_pkg.sv */
/*
 * Shared constants and carrier types for the bridge command and status bits.
 * Assumes a single core clock and an asynchronous active-low port reset.
 */
package bcs_pkg;

   // ----------------------------------------------------------------------
   // Register offsets and field positions
   // ----------------------------------------------------------------------
   localparam logic [11:0] BCS_OFS_COMMAND = 12'h004;
   localparam logic [11:0] BCS_OFS_STATUS  = 12'h006;
   localparam int BCS_BIT_SYS_ERR_EN   = 8;
   localparam int BCS_BIT_IRQ_DISABLE  = 10;
   localparam int BCS_BIT_IRQ_PENDING  = 3;
   localparam int BCS_BIT_CAP_LIST     = 4;
   localparam int BCS_BIT_TGT_ABORT    = 11;
   localparam int BCS_BIT_SIG_SYS_ERR  = 14;
   localparam int BCS_BIT_POISON       = 15;
   localparam logic BCS_RST_SYS_ERR_EN  = 1'h0;
   localparam logic BCS_RST_IRQ_DISABLE = 1'h0;
   localparam logic BCS_RST_STICKY      = 1'h0;
   localparam logic BCS_CAP_LIST_VALUE  = 1'h1;

   // ----------------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [15:0] wdata;
      logic [1:0]  be;
   } bcs_cfg_req_s;

   typedef struct packed {
      logic nonfatal;
      logic fatal;
      logic cor;
   } bcs_err_msg_s;

endpackage

/* File: bcs_sticky.sv */
/*
 * One write-one-to-clear status flag.
 * Assumes the clear strobe carries the written bit already qualified.
 */
`timescale 1ns/10ps
module bcs_sticky (
   // Clock and reset
   input  wire logic I_CLK_SYS,
   input  wire logic I_RST_B,
   // Event and clear
   input  wire logic i_set,
   input  wire logic i_clr,
   // Flag
   output logic      o_flag
);
   // ----------------------------------------------------------------------
   // Flag register
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic flag;
   } bcs_sticky_state_s;

   bcs_sticky_state_s st_r;
   bcs_sticky_state_s st_nxt;

   // A set in the clearing cycle wins so no event is lost.
   always_comb begin
      st_nxt = st_r;
      if (i_set) begin
         st_nxt.flag = 1'h1;
      end else if (i_clr) begin
         st_nxt.flag = 1'h0;
      end
   end

   // The flag returns to its default on port reset.
   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         st_r <= '{flag: bcs_pkg::BCS_RST_STICKY};
      end else begin
         st_r <= st_nxt;
      end
   end

   // The flag leaves straight from its flip-flop.
   assign o_flag = st_r.flag;
endmodule // bcs_sticky

/* File: bcs_fwd.sv */
/*
 * Registered forwarding of error messages and legacy interrupts.
 * Assumes message strobes are one-cycle pulses on the core clock.
 */
`timescale 1ns/10ps
module bcs_fwd (
   // Clock and reset
   input  wire logic                  I_CLK_SYS,
   input  wire logic                  I_RST_B,
   // Controls
   input  wire logic                  i_sys_err_en,
   // Secondary side traffic
   input  wire bcs_pkg::bcs_err_msg_s i_sec_msg,
   input  wire logic                  i_sec_intx,
   // Primary side traffic
   output bcs_pkg::bcs_err_msg_s      o_pri_msg,
   output logic                       o_pri_intx
);
   // ----------------------------------------------------------------------
   // Forwarding registers
   // ----------------------------------------------------------------------
   typedef struct packed {
      bcs_pkg::bcs_err_msg_s msg;
      logic                  intx;
   } bcs_fwd_state_s;

   bcs_fwd_state_s st_r;
   bcs_fwd_state_s st_nxt;

   // Non-fatal and fatal classes gate on the enable; correctable and interrupts never do.
   always_comb begin
      st_nxt.msg.nonfatal = i_sec_msg.nonfatal & i_sys_err_en;
      st_nxt.msg.fatal    = i_sec_msg.fatal & i_sys_err_en;
      st_nxt.msg.cor      = i_sec_msg.cor;
      st_nxt.intx         = i_sec_intx;
   end

   // Forwarded traffic restarts idle on port reset.
   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs leave straight from the forwarding flip-flops.
   assign o_pri_msg  = st_r.msg;
   assign o_pri_intx = st_r.intx;
endmodule // bcs_fwd

/* File: bcs_top.sv */
/*
 * Upper command bits and status register of a switch port bridge.
 * Assumes configuration requests are one-cycle strobes, read data valid a
 * cycle later, and that the downstream/upstream strap is stable.
 */
`timescale 1ns/10ps
module bcs_top (
   // Clock and reset
   input  wire logic                  I_CLK_SYS,
   input  wire logic                  I_RST_B,
   // Port configuration
   input  wire logic                  I_IS_DOWNSTREAM,
   // Configuration access
   input  wire bcs_pkg::bcs_cfg_req_s I_CFG_REQ,
   output logic [15:0]                O_CFG_RDATA,
   output logic                       O_CFG_RVALID,
   // Error sources
   input  wire logic                  I_ERR_DET_NONFATAL,
   input  wire logic                  I_ERR_DET_FATAL,
   input  wire logic                  I_DEVCTL_NONFATAL_EN,
   input  wire logic                  I_DEVCTL_FATAL_EN,
   input  wire logic                  I_PRI_POISON_RX,
   // Message and interrupt traffic
   input  wire bcs_pkg::bcs_err_msg_s I_SEC_MSG,
   input  wire logic                  I_SEC_INTX,
   input  wire logic                  I_HP_IRQ,
   output bcs_pkg::bcs_err_msg_s      O_PRI_MSG,
   output logic                       O_PRI_INTX,
   output logic                       O_OWN_INTX,
   output logic                       O_SYS_ERR_EN,
   output logic                       O_IRQ_DISABLE
);
   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic        sys_err_en;
      logic        irq_disable;
      logic        own_intx;
      logic        irq_pending;
      logic [15:0] rdata;
      logic        rvalid;
      logic        rep_nonfatal;
      logic        rep_fatal;
      bcs_pkg::bcs_err_msg_s pri_msg;
   } bcs_state_s;

   bcs_state_s st_r;
   bcs_state_s st_nxt;
   logic       sig_sys_err;
   logic       poison_flag;
   logic       wr_cmd_hi;
   logic       wr_sts_hi;
   logic       send_nonfatal;
   logic       send_fatal;
   logic       own_irq_src;
   bcs_pkg::bcs_err_msg_s fwd_msg;

   // Decode of writes reaching the upper byte of each register.
   assign wr_cmd_hi = I_CFG_REQ.wr & I_CFG_REQ.be[1] &
                      (I_CFG_REQ.addr == bcs_pkg::BCS_OFS_COMMAND);
   assign wr_sts_hi = I_CFG_REQ.wr & I_CFG_REQ.be[1] &
                      (I_CFG_REQ.addr == bcs_pkg::BCS_OFS_STATUS);

   // Own error messages are sent when any enable admits them.
   assign send_nonfatal = I_ERR_DET_NONFATAL & (st_r.sys_err_en | I_DEVCTL_NONFATAL_EN);
   assign send_fatal    = I_ERR_DET_FATAL & (st_r.sys_err_en | I_DEVCTL_FATAL_EN);

   // The bridge's own interrupt source is only the hot-plug controller downstream.
   assign own_irq_src = I_IS_DOWNSTREAM & I_HP_IRQ;

   // ----------------------------------------------------------------------
   // Write-one-to-clear status flags
   // ----------------------------------------------------------------------
   bcs_sticky u_sse (
      .I_CLK_SYS (I_CLK_SYS),
      .I_RST_B   (I_RST_B),
      .i_set     ((send_nonfatal | send_fatal) & st_r.sys_err_en),
      .i_clr     (wr_sts_hi & I_CFG_REQ.wdata[bcs_pkg::BCS_BIT_SIG_SYS_ERR]),
      .o_flag    (sig_sys_err)
   );

   bcs_sticky u_dpe (
      .I_CLK_SYS (I_CLK_SYS),
      .I_RST_B   (I_RST_B),
      .i_set     (I_PRI_POISON_RX),
      .i_clr     (wr_sts_hi & I_CFG_REQ.wdata[bcs_pkg::BCS_BIT_POISON]),
      .o_flag    (poison_flag)
   );

   // ----------------------------------------------------------------------
   // Forwarding path
   // ----------------------------------------------------------------------
   bcs_fwd u_fwd (
      .I_CLK_SYS    (I_CLK_SYS),
      .I_RST_B      (I_RST_B),
      .i_sys_err_en (st_r.sys_err_en),
      .i_sec_msg    (I_SEC_MSG),
      .i_sec_intx   (I_SEC_INTX),
      .o_pri_msg    (fwd_msg),
      .o_pri_intx   (O_PRI_INTX)
   );

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   // Register writes, interrupt state and read data are computed here.
   always_comb begin
      st_nxt = st_r;
      st_nxt.rvalid = I_CFG_REQ.rd;
      st_nxt.rep_nonfatal = send_nonfatal;
      st_nxt.rep_fatal = send_fatal;
      st_nxt.pri_msg.nonfatal = fwd_msg.nonfatal | st_r.rep_nonfatal;
      st_nxt.pri_msg.fatal    = fwd_msg.fatal | st_r.rep_fatal;
      st_nxt.pri_msg.cor      = fwd_msg.cor;
      if (wr_cmd_hi) begin
         st_nxt.sys_err_en  = I_CFG_REQ.wdata[bcs_pkg::BCS_BIT_SYS_ERR_EN];
         st_nxt.irq_disable = I_CFG_REQ.wdata[bcs_pkg::BCS_BIT_IRQ_DISABLE];
      end
      st_nxt.irq_pending = own_irq_src;
      st_nxt.own_intx    = own_irq_src & ~st_r.irq_disable;
      st_nxt.rdata = 16'h0000;
      if (I_CFG_REQ.rd) begin
         if (I_CFG_REQ.addr == bcs_pkg::BCS_OFS_COMMAND) begin
            st_nxt.rdata[bcs_pkg::BCS_BIT_SYS_ERR_EN]  = st_r.sys_err_en;
            st_nxt.rdata[bcs_pkg::BCS_BIT_IRQ_DISABLE] = st_r.irq_disable;
         end else if (I_CFG_REQ.addr == bcs_pkg::BCS_OFS_STATUS) begin
            st_nxt.rdata[bcs_pkg::BCS_BIT_IRQ_PENDING] = st_r.irq_pending;
            st_nxt.rdata[bcs_pkg::BCS_BIT_CAP_LIST]    = bcs_pkg::BCS_CAP_LIST_VALUE;
            st_nxt.rdata[bcs_pkg::BCS_BIT_TGT_ABORT]   = 1'h0;
            st_nxt.rdata[bcs_pkg::BCS_BIT_SIG_SYS_ERR] = sig_sys_err;
            st_nxt.rdata[bcs_pkg::BCS_BIT_POISON]      = poison_flag;
         end
      end
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   // All control state returns to defaults on port reset.
   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         st_r <= '{sys_err_en:  bcs_pkg::BCS_RST_SYS_ERR_EN,
                   irq_disable: bcs_pkg::BCS_RST_IRQ_DISABLE,
                   default:     '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Every output but O_PRI_INTX, which comes from the forwarding flip-flop, leaves straight from a field of the state register.
   assign O_PRI_MSG     = st_r.pri_msg;
   assign O_CFG_RDATA   = st_r.rdata;
   assign O_CFG_RVALID  = st_r.rvalid;
   assign O_OWN_INTX    = st_r.own_intx;
   assign O_SYS_ERR_EN  = st_r.sys_err_en;
   assign O_IRQ_DISABLE = st_r.irq_disable;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   // Bits that may read as one in each register; every other bit stays zero.
   localparam logic [15:0] CMD_LIVE = (16'h0001 << bcs_pkg::BCS_BIT_SYS_ERR_EN) |
                                      (16'h0001 << bcs_pkg::BCS_BIT_IRQ_DISABLE);
   localparam logic [15:0] STS_LIVE = (16'h0001 << bcs_pkg::BCS_BIT_IRQ_PENDING) |
                                      (16'h0001 << bcs_pkg::BCS_BIT_CAP_LIST) |
                                      (16'h0001 << bcs_pkg::BCS_BIT_SIG_SYS_ERR) |
                                      (16'h0001 << bcs_pkg::BCS_BIT_POISON);

   // Message forwarding and reporting checks look at the primary side two edges on; the blocking and interrupt checks one edge on.
   a_fwd_gate_fatal: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      (I_SEC_MSG.fatal && st_r.sys_err_en) |-> ##2 O_PRI_MSG.fatal)
      else $error("fatal message not forwarded");
   a_fwd_block_nonfatal: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      (I_SEC_MSG.nonfatal && !st_r.sys_err_en && !send_nonfatal) |=> !fwd_msg.nonfatal)
      else $error("non-fatal message forwarded while disabled");
   a_fwd_cor_always: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      I_SEC_MSG.cor |-> ##2 O_PRI_MSG.cor)
      else $error("correctable message dropped");
   a_err_report_dev: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      (I_ERR_DET_FATAL && I_DEVCTL_FATAL_EN) |-> ##2 O_PRI_MSG.fatal)
      else $error("fatal error not reported");
   a_intx_disable: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      $past(st_r.irq_disable) |-> !O_OWN_INTX)
      else $error("own interrupt while disabled");
   a_intx_fwd_pass: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      I_SEC_INTX |=> O_PRI_INTX)
      else $error("forwarded interrupt blocked");
   a_pending_upstream: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      (!I_IS_DOWNSTREAM && !$past(I_IS_DOWNSTREAM)) |-> !st_r.irq_pending)
      else $error("pending set on upstream port");
   a_pending_follows: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      (I_IS_DOWNSTREAM && I_HP_IRQ) |=> st_r.irq_pending)
      else $error("pending not set by hot-plug interrupt");
   a_status_fixed: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      (I_CFG_REQ.rd && I_CFG_REQ.addr == bcs_pkg::BCS_OFS_STATUS) |=>
      (O_CFG_RDATA[bcs_pkg::BCS_BIT_CAP_LIST] && !O_CFG_RDATA[bcs_pkg::BCS_BIT_TGT_ABORT] &&
       ((O_CFG_RDATA & ~STS_LIVE) == 16'h0000)))
      else $error("fixed status bits wrong");
   a_sse_sets: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      ((send_fatal || send_nonfatal) && st_r.sys_err_en) |=> sig_sys_err)
      else $error("signalled system error not set");
   a_dpe_sticks: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      (poison_flag && !(wr_sts_hi && I_CFG_REQ.wdata[bcs_pkg::BCS_BIT_POISON])) |=>
      poison_flag)
      else $error("poison flag lost without clear");
   a_dpe_sets: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      I_PRI_POISON_RX |=> poison_flag)
      else $error("poison flag not set");

   // ----------------------------------------------------------------------
   // Register file checks
   // ----------------------------------------------------------------------
   // A read of the command register taken on this edge.
   sequence s_cmd_read;
      I_CFG_REQ.rd && (I_CFG_REQ.addr == bcs_pkg::BCS_OFS_COMMAND);
   endsequence

   // A read of the status register taken on this edge.
   sequence s_sts_read;
      I_CFG_REQ.rd && (I_CFG_REQ.addr == bcs_pkg::BCS_OFS_STATUS);
   endsequence

   // A write of one to the signalled system error bit with no event beside it.
   sequence s_sse_clear_only;
      wr_sts_hi && I_CFG_REQ.wdata[bcs_pkg::BCS_BIT_SIG_SYS_ERR] &&
      !((send_fatal || send_nonfatal) && st_r.sys_err_en);
   endsequence

   // A write of one to the poison bit with no poisoned packet beside it.
   sequence s_dpe_clear_only;
      wr_sts_hi && I_CFG_REQ.wdata[bcs_pkg::BCS_BIT_POISON] && !I_PRI_POISON_RX;
   endsequence

   // A command write to the upper byte, followed by the edge that shows it.
   sequence s_cmd_write_done;
      wr_cmd_hi ##1 1'h1;
   endsequence

   // Read data must carry nothing but the live bits, and only in the answer cycle.
   a_cmd_reserved: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      s_cmd_read |=> ((O_CFG_RDATA & ~CMD_LIVE) == 16'h0000))
      else $error("reserved command bit reads one");
   a_idle_rdata: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      !I_CFG_REQ.rd |=> (O_CFG_RDATA == 16'h0000))
      else $error("read data outside an answer");
   a_cmd_readback: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      s_cmd_read |=> (O_CFG_RDATA[bcs_pkg::BCS_BIT_SYS_ERR_EN] == $past(O_SYS_ERR_EN) &&
                      O_CFG_RDATA[bcs_pkg::BCS_BIT_IRQ_DISABLE] == $past(O_IRQ_DISABLE)))
      else $error("command bits read back wrong");
   a_pending_read: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      s_sts_read |=> (O_CFG_RDATA[bcs_pkg::BCS_BIT_IRQ_PENDING] == $past(st_r.irq_pending)))
      else $error("pending bit read back wrong");
   a_sse_read: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      s_sts_read |=> (O_CFG_RDATA[bcs_pkg::BCS_BIT_SIG_SYS_ERR] == $past(sig_sys_err)))
      else $error("signalled system error read back wrong");
   a_dpe_read: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      s_sts_read |=> (O_CFG_RDATA[bcs_pkg::BCS_BIT_POISON] == $past(poison_flag)))
      else $error("poison bit read back wrong");

   // Clearing writes of one must empty a flag unless an event lands beside them.
   a_sse_clears: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      s_sse_clear_only |=> !sig_sys_err)
      else $error("signalled system error not cleared");
   a_sse_sticks: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      (sig_sys_err && !(wr_sts_hi && I_CFG_REQ.wdata[bcs_pkg::BCS_BIT_SIG_SYS_ERR])) |=>
      sig_sys_err)
      else $error("signalled system error lost without clear");
   a_dpe_clears: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      s_dpe_clear_only |=> !poison_flag)
      else $error("poison flag not cleared");

   // Command bits change only through a write reaching the upper byte.
   a_cmd_takes: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      s_cmd_write_done |->
      (O_SYS_ERR_EN == $past(I_CFG_REQ.wdata[bcs_pkg::BCS_BIT_SYS_ERR_EN]) &&
       O_IRQ_DISABLE == $past(I_CFG_REQ.wdata[bcs_pkg::BCS_BIT_IRQ_DISABLE])))
      else $error("command write not taken");
   a_cmd_holds: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      !wr_cmd_hi |=> ($stable(O_SYS_ERR_EN) && $stable(O_IRQ_DISABLE)))
      else $error("command bits moved without a write");

   // The bridge's own interrupt follows the hot-plug source on a downstream port only; non-fatal messages forward once enabled.
   a_own_upstream: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      !I_IS_DOWNSTREAM |=> !O_OWN_INTX)
      else $error("own interrupt on upstream port");
   a_own_follows: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      (I_IS_DOWNSTREAM && I_HP_IRQ && !O_IRQ_DISABLE) |=> O_OWN_INTX)
      else $error("own interrupt not raised");
   a_fwd_nonfatal_on: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
      (I_SEC_MSG.nonfatal && st_r.sys_err_en) |-> ##2 O_PRI_MSG.nonfatal)
      else $error("non-fatal message not forwarded");
endmodule // bcs_top

/* File: bcs_rc_model.sv */
/*
 * Configuration software model that issues accesses to the bridge bits.
 * Assumes requests are taken on a rising edge and read data follows a cycle later.
 */
`timescale 1ns/10ps
module bcs_rc_model (
   // Clock
   input  wire logic             i_clk,
   // Read answer
   input  wire logic [15:0]      i_rdata,
   input  wire logic             i_rvalid,
   // Request
   output bcs_pkg::bcs_cfg_req_s o_req
);
   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   // The request starts idle with junk on the qualifier lines.
   initial o_req = '{wr: 1'b0, rd: 1'b0, addr: 12'hfff, wdata: 16'hffff, be: 2'b00};

   // A write is held for one taking edge, then released with inverted lines.
   task cfg_wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] be);
      @(negedge i_clk);
      o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d, be: be};
      @(negedge i_clk);
      o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d, be: ~be};
   endtask

   // A read is held for one taking edge; the answer is picked up a cycle later.
   task cfg_rd(input logic [11:0] a, output logic [15:0] d, output logic v);
      @(negedge i_clk);
      o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h5a5a, be: 2'b11};
      @(negedge i_clk);
      o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'ha5a5, be: 2'b00};
      v = i_rvalid;
      d = i_rdata;
   endtask
endmodule // bcs_rc_model

/* File: bcs_top_tb.sv */
/*
 * Self-checking bench for the bridge command and status bits.
 * Assumes the design package is compiled first and inputs move on falling edges.
 */
`timescale 1ns/10ps
module bcs_top_tb;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   typedef struct packed {
      logic [15:0] wdata;
      logic [1:0]  be;
      logic [15:0] exp;
   } bcs_row_s;
   localparam logic [11:0] CMD = bcs_pkg::BCS_OFS_COMMAND;
   localparam logic [11:0] STS = bcs_pkg::BCS_OFS_STATUS;
   logic                  clk = 1'b0;
   logic                  rst_b, dn, nf, ft, en_nf, en_ft, poison, sec_intx, hp;
   logic                  rvalid, pri_intx, own_intx, serr_en, irq_dis;
   logic [15:0]           rdata;
   logic [2:0]            seen;
   bcs_pkg::bcs_cfg_req_s req;
   bcs_pkg::bcs_err_msg_s sec, pri;
   int                    num_errors = 0;
   int                    n_checks = 0;
   int                    cyc = 0;
   bcs_row_s              rows [5] = '{'{16'h0100, 2'b10, 16'h0100},
      '{16'h0400, 2'b10, 16'h0400}, '{16'hffff, 2'b10, 16'h0500},
      '{16'h0000, 2'b01, 16'h0500}, '{16'hfaff, 2'b10, 16'h0000}};

   // Core clock at 200 MHz.
   always #2.5 clk = ~clk;

   bcs_rc_model u_bcs_rc_model (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));

   bcs_top u_bcs_top (
      .I_CLK_SYS(clk), .I_RST_B(rst_b), .I_IS_DOWNSTREAM(dn), .I_CFG_REQ(req),
      .O_CFG_RDATA(rdata), .O_CFG_RVALID(rvalid), .I_ERR_DET_NONFATAL(nf),
      .I_ERR_DET_FATAL(ft), .I_DEVCTL_NONFATAL_EN(en_nf), .I_DEVCTL_FATAL_EN(en_ft),
      .I_PRI_POISON_RX(poison), .I_SEC_MSG(sec), .I_SEC_INTX(sec_intx), .I_HP_IRQ(hp),
      .O_PRI_MSG(pri), .O_PRI_INTX(pri_intx), .O_OWN_INTX(own_intx),
      .O_SYS_ERR_EN(serr_en), .O_IRQ_DISABLE(irq_dis));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Compares one value and counts it.
   task check(input string what, input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // Reads a register and checks both the answer strobe and the data.
   task rd_chk(input logic [11:0] a, input logic [15:0] exp);
      logic [15:0] d;
      logic        v;
      u_bcs_rc_model.cfg_rd(a, d, v);
      check("rvalid", 16'(v), 16'h0001);
      check("rdata", d, exp);
   endtask

   // Pulses message sources for a cycle and gathers what reaches the primary side.
   task send(input logic [2:0] s, input logic n, input logic f);
      seen = 3'h0;
      @(negedge clk);
      sec = bcs_pkg::bcs_err_msg_s'(s);
      nf = n;
      ft = f;
      @(negedge clk);
      sec = '0;
      nf = 1'b0;
      ft = 1'b0;
      repeat (4) begin
         seen = seen | pri;
         @(negedge clk);
      end
   endtask

   // Prints the verdict and ends the run.
   task stop_test;
      if (num_errors == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Cuts a hang short.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         num_errors++;
         stop_test;
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rst_b = 1'b0;
      {dn, nf, ft, en_nf, en_ft, poison, sec_intx, hp} = 8'h80;
      sec = '0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      rd_chk(STS, 16'h0010);
      rd_chk(CMD, 16'h0000);
      foreach (rows[i]) begin
         u_bcs_rc_model.cfg_wr(CMD, rows[i].wdata, rows[i].be);
         rd_chk(CMD, rows[i].exp);
         check("cmd_out", {14'h0, serr_en, irq_dis}, {14'h0, rows[i].exp[8], rows[i].exp[10]});
      end
      u_bcs_rc_model.cfg_wr(12'h008, 16'hffff, 2'b11);
      rd_chk(12'h008, 16'h0000);
      u_bcs_rc_model.cfg_wr(STS, 16'hffff, 2'b11);
      rd_chk(STS, 16'h0010);
      send(3'b111, 1'b1, 1'b1);
      check("msg_off", 16'(seen), 16'h0001);
      en_ft = 1'b1;
      send(3'b000, 1'b0, 1'b1);
      check("msg_devctl", 16'(seen), 16'h0002);
      rd_chk(STS, 16'h0010);
      en_ft = 1'b0;
      u_bcs_rc_model.cfg_wr(CMD, 16'h0100, 2'b10);
      send(3'b111, 1'b0, 1'b0);
      check("msg_on", 16'(seen), 16'h0007);
      send(3'b000, 1'b1, 1'b0);
      check("msg_own", 16'(seen), 16'h0004);
      rd_chk(STS, 16'h4010);
      @(negedge clk);
      poison = 1'b1;
      @(negedge clk);
      poison = 1'b0;
      u_bcs_rc_model.cfg_wr(STS, 16'h0000, 2'b11);
      rd_chk(STS, 16'hc010);
      u_bcs_rc_model.cfg_wr(STS, 16'hc000, 2'b11);
      rd_chk(STS, 16'h0010);
      hp = 1'b1;
      repeat (3) @(negedge clk);
      check("own_intx", 16'(own_intx), 16'h0001);
      rd_chk(STS, 16'h0018);
      u_bcs_rc_model.cfg_wr(CMD, 16'h0400, 2'b10);
      repeat (3) @(negedge clk);
      check("own_masked", 16'(own_intx), 16'h0000);
      sec_intx = 1'b1;
      hp = 1'b0;
      repeat (3) @(negedge clk);
      check("pri_intx", 16'(pri_intx), 16'h0001);
      rd_chk(STS, 16'h0010);
      rst_b = 1'b0;
      dn = 1'b0;
      hp = 1'b1;
      repeat (2) @(negedge clk);
      check("rst_out", {12'h0, pri_intx, own_intx, serr_en, irq_dis}, 16'h0000);
      rst_b = 1'b1;
      repeat (3) @(negedge clk);
      check("up_own", 16'(own_intx), 16'h0000);
      rd_chk(STS, 16'h0010);
      stop_test;
   end
endmodule // bcs_top_tb
